// >>> hwm_top.sv
// hardware monitor sequencer, limit status, voltage code capture and pin control
// assumes an APB master, an external converter answering conv_req_o with
// conv_done_i, and a pad giving the pin level plus a mid-level detect
//
// Decided for this implementation: the APB slave port and the register addresses.
`default_nettype none
`include "hwm_params.svh"
module hwm_top #(
	parameter int SLOT_CYC = `HWM_SLOT_CYC,
	parameter int RST_CYC = `HWM_RST_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device pins
	input wire logic [3:0] core_voltage_code_i,
	input wire logic twelve_volt_or_code_bit4_pin_i,
	input wire logic remote_diode_cathode_test_in_i,
	input wire logic multifunction_strap_pin_i,
	input wire logic multifunction_strap_pin_mid_i,
	output logic multifunction_strap_pin_o,
	output logic multifunction_strap_pin_oe_n_o,
	// serial engine start seen, same clock
	input wire logic smb_activity_i,
	// converter handshake
	output logic conv_req_o,
	output logic [2:0] conv_ch_o,
	input wire logic conv_done_i,
	input wire logic [7:0] conv_data_i,
	output logic irq_o
);
	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	// bit order: code0..3, code4 pin, diode test, strap level, strap mid
	logic [7:0] pin_s;
	hwm_sync #(.W(8)) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.d_i({multifunction_strap_pin_mid_i, multifunction_strap_pin_i,
			remote_diode_cathode_test_in_i, twelve_volt_or_code_bit4_pin_i,
			core_voltage_code_i}),
		.q_o(pin_s)
	);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	hwm_pkg::hwm_state_t r_q, r_d;
	logic acc; // access phase, first cycle
	logic wr; // write commits at the ready edge
	logic [2:0] bank; // register group
	logic [2:0] idx; // word inside group
	logic mapped; // address decodes
	logic [31:0] rdata; // read mux
	logic [7:0] chain; // nand chain node values
	logic [7:0] cv; // converter result
	logic [7:0] ev; // limit events this cycle
	logic slot_end; // slot timer expired

	// the access phase is answered on its second cycle: pready is a flop,
	// so the first access cycle only loads prdata and pslverr
	// decode of the current apb address
	always_comb begin
		acc = psel && penable && !r_q.pready;
		wr = psel && penable && pwrite && r_q.pready;
		bank = paddr[7:5];
		idx = paddr[4:2];
		mapped = (bank != `HWM_BANK_CFG) || (idx <= `HWM_OFF_INFO);
	end

	// read mux; unused bits read as zero
	always_comb begin
		rdata = '0;
		case (bank)
			`HWM_BANK_VAL: rdata[7:0] = r_q.val[idx];
			`HWM_BANK_HI: rdata[7:0] = r_q.lim_hi[idx];
			`HWM_BANK_LO: rdata[7:0] = r_q.lim_lo[idx];
			`HWM_BANK_CFG: begin
				case (idx)
					`HWM_OFF_CTRL: begin
						rdata[`HWM_CTRL_START] = r_q.start;
						rdata[`HWM_CTRL_CORE_VOLTAGE_CODE_BIT4] = r_q.core_voltage_code_bit4_mode;
						rdata[`HWM_CTRL_FN_HI:`HWM_CTRL_FN_LO] = r_q.pinfn;
						rdata[`HWM_CTRL_RGO] = r_q.rst_act;
					end
					`HWM_OFF_STAT: rdata[7:0] = r_q.stat;
					`HWM_OFF_MASK: rdata[7:0] = r_q.mask;
					`HWM_OFF_VID: rdata[4:0] = r_q.vid;
					`HWM_OFF_INFO: begin
						rdata[6:0] = {`HWM_ADDR_HI, r_q.addr_lo};
						rdata[`HWM_INFO_DONE] = r_q.strap_done;
						rdata[`HWM_INFO_TEST] = r_q.test_mode;
						rdata[`HWM_INFO_CH+:3] = r_q.ch;
					end
					default: rdata = '0;
				endcase
			end
			default: rdata = '0;
		endcase
	end

	// only the five code inputs take part; the result is meaningful
	// while test mode holds the sequencer still
	// nand chain over the digital inputs, for board connectivity test
	always_comb begin
		chain = '0;
		chain[0] = pin_s[0];
		for (int i = 1; i < 5; i++) begin
			chain[i] = !(chain[i-1] && pin_s[i]);
		end
	end

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		ev = '0;
		cv = conv_data_i;
		// last cycle of a slot of SLOT_CYC cycles
		slot_end = (r_q.slot_cnt == 20'(SLOT_CYC - 1));

		// apb: one wait state, then pready for a single cycle
		r_d.pready = acc;
		r_d.pslverr = acc && !mapped;
		if (acc) begin
			r_d.prdata = rdata;
		end

		// test strap caught a few edges after reset, once the sync settles
		if (!r_q.boot_done) begin
			r_d.boot_cnt = r_q.boot_cnt + 3'h1;
			if (r_q.boot_cnt == `HWM_BOOT_CYC) begin
				r_d.boot_done = 1'b1;
				r_d.test_mode = pin_s[5];
			end
		end

		// strap sampled once on first bus activity, only while undriven
		if (smb_activity_i && !r_q.strap_done && r_q.boot_done && r_q.pin_oe_n) begin
			r_d.strap_done = 1'b1;
			// mid level means open pin
			r_d.addr_lo = pin_s[7] ? `HWM_STRAP_OPEN : {1'b0, pin_s[6]};
		end

		// code inputs captured continuously; bit 4 forced low in analog mode
		r_d.vid = {r_q.core_voltage_code_bit4_mode && pin_s[4], pin_s[3:0]};

		// sequencer: one slot per channel, eight slots per cycle
		r_d.conv_req = 1'b0;
		if (r_q.seq != hwm_pkg::HWM_S_IDLE) begin
			r_d.slot_cnt = r_q.slot_cnt + 20'h1;
		end
		case (r_q.seq)
			hwm_pkg::HWM_S_IDLE: begin
				r_d.slot_cnt = '0;
				if (r_q.start && r_q.boot_done && !r_q.test_mode) begin
					r_d.seq = hwm_pkg::HWM_S_REQ;
				end
			end
			hwm_pkg::HWM_S_REQ: begin
				r_d.conv_req = 1'b1;
				r_d.seq = hwm_pkg::HWM_S_WAIT;
			end
			hwm_pkg::HWM_S_WAIT: begin
				if (conv_done_i) begin
					r_d.val[r_q.ch] = cv;
					// the 12 V channel is not judged when its pin reads a code bit
					if (!(r_q.core_voltage_code_bit4_mode && r_q.ch == `HWM_V12_CH)) begin
						ev[r_q.ch] = (cv > r_q.lim_hi[r_q.ch]) || (cv < r_q.lim_lo[r_q.ch]);
					end
					r_d.seq = hwm_pkg::HWM_S_HOLD;
				end
				// silent or late converter: move on at the slot end all the same;
				// parking in hold past the end count would stall the whole cycle
				if (slot_end) begin
					r_d.slot_cnt = '0;
					r_d.ch = r_q.ch + 3'h1;
					r_d.seq = r_q.start ? hwm_pkg::HWM_S_REQ : hwm_pkg::HWM_S_IDLE;
				end
			end
			hwm_pkg::HWM_S_HOLD: begin
				// result taken, sit out the rest of the slot
				if (slot_end) begin
					r_d.slot_cnt = '0;
					r_d.ch = r_q.ch + 3'h1;
					r_d.seq = r_q.start ? hwm_pkg::HWM_S_REQ : hwm_pkg::HWM_S_IDLE;
				end
			end
			default: r_d.seq = hwm_pkg::HWM_S_IDLE;
		endcase

		// register writes; status is write-one-to-clear
		r_d.stat = r_q.stat | ev;
		if (wr) begin
			case (bank)
				`HWM_BANK_HI: r_d.lim_hi[idx] = pwdata[7:0];
				`HWM_BANK_LO: r_d.lim_lo[idx] = pwdata[7:0];
				`HWM_BANK_CFG: begin
					case (idx)
						`HWM_OFF_CTRL: begin
							r_d.start = pwdata[`HWM_CTRL_START];
							r_d.core_voltage_code_bit4_mode = pwdata[`HWM_CTRL_CORE_VOLTAGE_CODE_BIT4];
							r_d.pinfn = hwm_pkg::hwm_pinfn_t'(pwdata[`HWM_CTRL_FN_HI:`HWM_CTRL_FN_LO]);
							// reset pulse starts only in reset mode
							if (pwdata[`HWM_CTRL_RGO] && !r_q.rst_act &&
								pwdata[`HWM_CTRL_FN_HI:`HWM_CTRL_FN_LO] == hwm_pkg::HWM_PF_RST) begin
								r_d.rst_act = 1'b1;
								r_d.rst_cnt = '0;
							end
						end
						// set wins over the clear
						`HWM_OFF_STAT: r_d.stat = (r_q.stat & ~pwdata[7:0]) | ev;
						`HWM_OFF_MASK: r_d.mask = pwdata[7:0];
						default: r_d.mask = r_d.mask;
					endcase
				end
				default: r_d.mask = r_d.mask;
			endcase
		end

		// frozen cycles do not count, so a held clock enable only stretches it
		// reset pulse timer, exact least length
		if (r_q.rst_act) begin
			r_d.rst_cnt = r_q.rst_cnt + 20'h1;
			if (r_q.rst_cnt == 20'(RST_CYC - 1)) begin
				r_d.rst_act = 1'b0;
			end
		end

		// interrupt level from masked sticky bits
		r_d.irq = |(r_d.stat & r_d.mask);

		// outside test mode the pin is only ever pulled low; test mode drives
		// the chain output both ways, so a strap to ground must not be fitted
		// pin driver, open-drain style; test mode has priority
		r_d.pin_o = 1'b0;
		r_d.pin_oe_n = 1'b1;
		if (r_d.test_mode) begin
			r_d.pin_o = chain[4];
			r_d.pin_oe_n = 1'b0;
		end else if (r_d.rst_act) begin
			r_d.pin_oe_n = 1'b0;
		end else if (r_d.pinfn == hwm_pkg::HWM_PF_INT && r_d.irq) begin
			r_d.pin_oe_n = 1'b0;
		end
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	// constants only under reset; strap and test levels are caught later
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_q <= '0;
			r_q.seq <= hwm_pkg::HWM_S_IDLE;
			r_q.pinfn <= hwm_pkg::HWM_PF_NONE;
			r_q.lim_hi <= {8{`HWM_LIM_HI_RST}};
			r_q.lim_lo <= {8{`HWM_LIM_LO_RST}};
			r_q.pin_oe_n <= 1'b1;
		end else if (ce_i) begin
			r_q <= r_d;
		end
	end

	// outputs straight from the state register
	assign prdata = r_q.prdata;
	assign pready = r_q.pready;
	assign pslverr = r_q.pslverr;
	assign multifunction_strap_pin_o = r_q.pin_o;
	assign multifunction_strap_pin_oe_n_o = r_q.pin_oe_n;
	assign conv_req_o = r_q.conv_req;
	assign conv_ch_o = r_q.ch;
	assign irq_o = r_q.irq;
endmodule
`default_nettype wire

// >>> hwm_params.svh
// constants of the hardware monitor sequencer and pin control
// assumes a 25 MHz core clock and an 8-bit APB byte address
`ifndef HWM_PARAMS_SVH
`define HWM_PARAMS_SVH

// --------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------
`define HWM_CLK_KHZ 25000
`define HWM_CYCLE_US 114400
`define HWM_RST_US 20000
`define HWM_NCH 8
// divide first: the full product does not fit a 32-bit integer
`define HWM_SLOT_CYC (((`HWM_CYCLE_US / `HWM_NCH) * `HWM_CLK_KHZ) / 1000)
`define HWM_RST_CYC ((`HWM_RST_US * `HWM_CLK_KHZ + 999) / 1000)
`define HWM_BOOT_CYC 3'h4

// --------------------------------------------------------------
// register word offsets within a bank, and bank numbers
// --------------------------------------------------------------
`define HWM_OFF_CTRL 3'h0
`define HWM_OFF_STAT 3'h1
`define HWM_OFF_MASK 3'h2
`define HWM_OFF_VID 3'h3
`define HWM_OFF_INFO 3'h4
`define HWM_BANK_CFG 3'h0
`define HWM_BANK_VAL 3'h1
`define HWM_BANK_HI 3'h2
`define HWM_BANK_LO 3'h3

// --------------------------------------------------------------
// control fields and reset values
// --------------------------------------------------------------
`define HWM_CTRL_START 0
`define HWM_CTRL_CORE_VOLTAGE_CODE_BIT4 1
`define HWM_CTRL_FN_LO 2
`define HWM_CTRL_FN_HI 3
`define HWM_CTRL_RGO 4
`define HWM_INFO_DONE 7
`define HWM_INFO_TEST 8
`define HWM_INFO_CH 9
`define HWM_LIM_HI_RST 8'hFF
`define HWM_LIM_LO_RST 8'h00
`define HWM_ADDR_HI 5'h0B
`define HWM_STRAP_OPEN 2'h2
`define HWM_V12_CH 3'h0

`endif

// >>> hwm_pkg.sv
// types of the hardware monitor sequencer and pin control
// assumes hwm_params.svh is compiled alongside
`default_nettype none
package hwm_pkg;
	// sequencer states
	typedef enum logic [1:0] {
		HWM_S_IDLE = 2'h0,
		HWM_S_REQ = 2'h1,
		HWM_S_WAIT = 2'h2,
		HWM_S_HOLD = 2'h3
	} hwm_seq_t;
	// multifunction pin use; code 3 acts as none
	typedef enum logic [1:0] {
		HWM_PF_NONE = 2'h0,
		HWM_PF_RST = 2'h1,
		HWM_PF_INT = 2'h2,
		HWM_PF_RSV = 2'h3
	} hwm_pinfn_t;
	typedef logic [7:0][7:0] hwm_bank_t;
	// whole state of the top module
	typedef struct packed {
		hwm_seq_t seq;
		logic [2:0] ch;
		logic [19:0] slot_cnt;
		logic [19:0] rst_cnt;
		logic rst_act;
		logic start;
		logic core_voltage_code_bit4_mode;
		hwm_pinfn_t pinfn;
		logic [7:0] stat;
		logic [7:0] mask;
		logic [4:0] vid;
		hwm_bank_t val;
		hwm_bank_t lim_hi;
		hwm_bank_t lim_lo;
		logic [1:0] addr_lo;
		logic strap_done;
		logic test_mode;
		logic [2:0] boot_cnt;
		logic boot_done;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic conv_req;
		logic pin_o;
		logic pin_oe_n;
		logic irq;
	} hwm_state_t;
endpackage
`default_nettype wire

// >>> hwm_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to clk_i; output changes when stages 2 and 3 agree
`default_nettype none
module hwm_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// stage 1 feeds only stage 2
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} hwm_sync_t;
	hwm_sync_t r_q, r_d;

	// next state: shift, then accept bits whose last two stages agree
	always_comb begin
		r_d = r_q;
		r_d.s1 = d_i;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		for (int i = 0; i < W; i++) begin
			if (r_q.s2[i] == r_q.s3[i]) begin
				r_d.q[i] = r_q.s3[i];
			end
		end
	end

	// register, frozen while ce_i low
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_q <= '0;
		end else if (ce_i) begin
			r_q <= r_d;
		end
	end

	assign q_o = r_q.q;
endmodule
`default_nettype wire

// >>> hwm_top_props.sv
// port checks on the monitor top, bound into every hwm_top
// assumes one clock domain; counts arrive through the bind
`default_nettype none
module hwm_top_props #(
	parameter int SLOT_CYC = 20,
	parameter int RST_CYC = 10
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_req_o,
	input wire logic [2:0] conv_ch_o,
	input wire logic irq_o,
	input wire logic multifunction_strap_pin_o,
	input wire logic multifunction_strap_pin_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// slot body: no second request, channel held
	sequence s_slot;
		(!conv_req_o && $stable(conv_ch_o))[*8];
	endsequence
	// reset pulse body, shorter than the smallest count used
	sequence s_low;
		(!multifunction_strap_pin_oe_n_o && !multifunction_strap_pin_o)[*8];
	endsequence
	// cycles since the last converter request, saturating
	logic [31:0] gap_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_q <= 32'hFFFFFFFF;
		end else if (conv_req_o) begin
			gap_q <= 32'h00000001;
		end else if (gap_q != 32'hFFFFFFFF) begin
			gap_q <= gap_q + 32'h00000001;
		end
	end
	AST_SLOT_GAP: assert property (conv_req_o |-> gap_q >= 32'(SLOT_CYC))
		else $error("converter requests closer than one slot");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ONE_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait");
	AST_READY_CAUSE: assert property (pready |-> $past(psel) && $past(penable))
		else $error("pready without access");
	AST_ERR_UNMAPPED: assert property (pready && paddr[7:2] inside {6'h05, 6'h06, 6'h07} |-> pslverr)
		else $error("unmapped access not refused");
	AST_REQ_SLOT: assert property (conv_req_o |=> s_slot)
		else $error("slot cut short");
	AST_CH_STEP: assert property ($changed(conv_ch_o) |-> conv_ch_o == $past(conv_ch_o) + 3'h1)
		else $error("channel order broken");
	AST_RST_PULSE: assert property ($fell(multifunction_strap_pin_oe_n_o) && !irq_o
		&& !multifunction_strap_pin_o |-> s_low)
		else $error("reset pulse too short");
	AST_IDLE_START: assert property ($rose(nrst_i) |-> multifunction_strap_pin_oe_n_o && !irq_o)
		else $error("pin driven after reset");
endmodule
bind hwm_top hwm_top_props #(.SLOT_CYC(SLOT_CYC), .RST_CYC(RST_CYC)) u_props (.clk_i, .nrst_i,
	.psel, .penable, .paddr, .pready, .pslverr, .conv_req_o, .conv_ch_o, .irq_o,
	.multifunction_strap_pin_o, .multifunction_strap_pin_oe_n_o);
`default_nettype wire

// >>> hwm_conv_model.sv
// converter model answering the monitor's requests, prompt or slow
// assumes the request is a one-cycle pulse with the channel held
`default_nettype none
module hwm_conv_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic slow_i,
	input wire logic [7:0] base_i,
	input wire logic conv_req_i,
	input wire logic [2:0] conv_ch_i,
	output logic conv_done_o,
	output logic [7:0] conv_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy; // conversion under way
	logic [3:0] cnt; // wait before answering
	// data inverts every idle cycle, so a sample taken one cycle late never looks valid
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{busy, cnt, conv_done_o, conv_data_o} <= '0;
		end else begin
			conv_done_o <= 1'b0;
			conv_data_o <= ~conv_data_o;
			if (conv_req_i) begin
				busy <= 1'b1;
				cnt <= slow_i ? 4'h6 : 4'h0;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				conv_done_o <= 1'b1;
				conv_data_o <= base_i + {5'h00, conv_ch_i};
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test_hw_monitor_sequencer_pin_control.sv
// self-checking bench for the monitor sequencer and pin control
// assumes hwm_top, the converter model and the bound checker
`default_nettype none
module test_hw_monitor_sequencer_pin_control;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// stimulus, pad and instances
	// ----------------------------------------
	logic clk_i = 1'b0, nrst_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr, pin_o, oe_n, irq_o, creq, cdone, smb = 1'b0;
	logic diode = 1'b0, mid = 1'b0, strap = 1'b0, v12 = 1'b1, slow = 1'b0, ce = 1'b1;
	logic [3:0] code = 4'h0;
	logic [2:0] cch;
	logic [7:0] cdat;
	int errors = 0, n_tests = 0;
	// strap table: mid, level, expected low address bits
	localparam logic [3:0] TAB [3] = '{4'h0, 4'hE, 4'h5};
	wire logic pad = oe_n ? strap : pin_o; // strap level unless driven
	hwm_top #(.SLOT_CYC(20), .RST_CYC(10)) dut (.clk_i, .nrst_i, .ce_i(ce), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_voltage_code_i(code),
		.twelve_volt_or_code_bit4_pin_i(v12), .remote_diode_cathode_test_in_i(diode),
		.multifunction_strap_pin_i(pad), .multifunction_strap_pin_mid_i(mid),
		.multifunction_strap_pin_o(pin_o), .multifunction_strap_pin_oe_n_o(oe_n),
		.smb_activity_i(smb), .conv_req_o(creq), .conv_ch_o(cch), .conv_done_i(cdone),
		.conv_data_i(cdat), .irq_o);
	hwm_conv_model conv (.clk_i, .nrst_i, .slow_i(slow), .base_i(8'h40), .conv_req_i(creq),
		.conv_ch_i(cch), .conv_done_o(cdone), .conv_data_o(cdat));
	initial forever #20 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; request held until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst(input logic dio, input logic m, input logic s);
		nrst_i <= 1'b0;
		diode <= dio;
		mid <= m;
		strap <= s;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
	endtask
	task automatic test_strap;
		for (int i = 0; i < 3; i++) begin
			rst(1'b0, TAB[i][3], TAB[i][2]);
			chk("pin idle", oe_n, 1'b1);
			smb <= 1'b1;
			@(posedge clk_i);
			smb <= 1'b0;
			apb(1'b0, 8'h10, 32'h0);
			chk("info", rdat[8:0], {2'b01, 5'h0B, TAB[i][1:0]});
		end
		// a later bus start must not take the strap again
		strap <= 1'b0;
		smb <= 1'b1;
		@(posedge clk_i);
		smb <= 1'b0;
		repeat (6) @(posedge clk_i);
		apb(1'b0, 8'h10, 32'h0);
		chk("strap kept", rdat[6:0], {5'h0B, 2'b01});
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", rerr, 1'b1);
		chk("unmapped data", rdat, 32'h0);
		rst(1'b1, 1'b0, 1'b1);
		chk("tree drive", oe_n, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		chk("test flag", rdat[8], 1'b1);
		$display("strap test done");
	endtask
	task automatic test_code;
		rst(1'b0, 1'b0, 1'b1);
		code <= 4'hA;
		repeat (8) @(posedge clk_i);
		apb(1'b0, 8'h0C, 32'h0);
		chk("code analog", rdat, 32'h0A);
		apb(1'b1, 8'h00, 32'h02);
		repeat (8) @(posedge clk_i);
		apb(1'b0, 8'h0C, 32'h0);
		chk("code digital", rdat, 32'h1A);
		$display("code test done");
	endtask
	task automatic test_seq;
		rst(1'b0, 1'b0, 1'b1);
		slow <= 1'b1;
		apb(1'b1, 8'h4C, 32'h10); // channel 3 high limit under its result
		apb(1'b1, 8'h74, 32'h50); // channel 5 low limit over its result
		apb(1'b1, 8'h08, 32'h08);
		apb(1'b1, 8'h00, 32'h01);
		repeat (200) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'h20 + 8'(4 * i), 32'h0);
			chk("value", rdat, 32'h40 + i);
		end
		apb(1'b0, 8'h04, 32'h0);
		chk("status", rdat, 32'h28);
		chk("irq", irq_o, 1'b1);
		apb(1'b1, 8'h00, 32'h08); // stop, pin as interrupt
		repeat (2) @(posedge clk_i);
		chk("int pin", {oe_n, pin_o}, 2'b00);
		repeat (40) @(posedge clk_i);
		apb(1'b1, 8'h04, 32'h28);
		repeat (2) @(posedge clk_i);
		chk("irq clear", irq_o, 1'b0);
		chk("int release", oe_n, 1'b1);
		$display("sequence test done");
	endtask
	task automatic test_pulse;
		rst(1'b0, 1'b0, 1'b1);
		apb(1'b1, 8'h00, 32'h14);
		repeat (2) @(posedge clk_i);
		chk("pulse low", {oe_n, pin_o}, 2'b00);
		// frozen cycles must not count toward the pulse
		ce <= 1'b0;
		repeat (20) @(posedge clk_i);
		ce <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("pulse held", oe_n, 1'b0);
		@(posedge clk_i);
		chk("pulse end", oe_n, 1'b1);
		$display("pulse test done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		test_strap;
		test_code;
		test_seq;
		test_pulse;
		report_and_stop;
	end
	// watchdog, well beyond the whole run
	initial begin
		repeat (4000) @(posedge clk_i);
		errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
